/* src/rwp_top.v */
// register write protect: protect registers and guarded write gate
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`include "rwp_consts.vh"
module rwp_top #(
  parameter AW = `RWP_AW,
  parameter DW = `RWP_DW,
  parameter [`RWP_G0_N*`RWP_AW-1:0] G0_LIST = `RWP_G0_LIST,
  parameter [`RWP_G1_N*`RWP_AW-1:0] G1_LIST = `RWP_G1_LIST,
  parameter [`RWP_G2_N*`RWP_AW-1:0] G2_LIST = `RWP_G2_LIST,
  parameter [`RWP_G3_N*`RWP_AW-1:0] G3_LIST = `RWP_G3_LIST,
  parameter [`RWP_G4_N*`RWP_AW-1:0] G4_LIST = `RWP_G4_LIST,
  parameter [`RWP_G5_N*`RWP_AW-1:0] G5_LIST = `RWP_G5_LIST
) (
  input wire core_clk,
  input wire rst,
  // cpu register port
  input wire [AW-1:0] bus_addr,
  input wire [DW-1:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [DW-1:0] bus_rdata,
  // gated write towards the system registers
  output reg sys_wr,
  output reg [AW-1:0] sys_addr,
  output reg [DW-1:0] sys_wdata,
  // pulse for each refused write
  output reg wr_blocked,
  // current group enables, for observation
  output reg [`RWP_NGRP-1:0] grp_open
);

  // hazard: a guarded write must never reach the system while its
  // group is shut; all refusal logic below is combinational on the
  // stored enables and only the verdict is registered
  // protect registers
  reg [DW-1:0] key_r; // protect_key
  reg [DW-1:0] key_nxt;
  reg [DW-1:0] main_r; // protect_control_main
  reg [DW-1:0] main_nxt;
  reg [DW-1:0] power_r; // protect_control_power
  reg [DW-1:0] power_nxt;
  reg [DW-1:0] clock4_r; // protect_control_clock4
  reg [DW-1:0] clock4_nxt;

  // status: sticky blocked flag and group of the last refusal
  reg stat_blk_r;
  reg stat_blk_nxt;
  reg [`RWP_NGRP-1:0] stat_grp_r;
  reg [`RWP_NGRP-1:0] stat_grp_nxt;

  // own register decode; full compare on all address bits, so no
  // alias of a protect register can slip past the guard
  wire hit_key;
  wire hit_main;
  wire hit_power;
  wire hit_clock4;
  wire hit_stat;
  wire hit_own;

  assign hit_key = (bus_addr == `RWP_OFS_KEY);
  assign hit_main = (bus_addr == `RWP_OFS_MAIN);
  assign hit_power = (bus_addr == `RWP_OFS_POWER);
  assign hit_clock4 = (bus_addr == `RWP_OFS_CLOCK4);
  assign hit_stat = (bus_addr == `RWP_OFS_STAT);
  // own registers never go through the guard
  assign hit_own = hit_key | hit_main | hit_power | hit_clock4 | hit_stat;

  // guarded group decode, one matcher per group; the lists are
  // parameters so a target can move without touching this logic
  wire [`RWP_NGRP-1:0] grp_hit; // bit g: address lies in group g

  rwp_match #(
    .N(`RWP_G0_N),
    .AW(AW),
    .LIST(G0_LIST)
  ) u_g0 (
    .addr(bus_addr),
    .hit(grp_hit[0])
  );

  rwp_match #(
    .N(`RWP_G1_N),
    .AW(AW),
    .LIST(G1_LIST)
  ) u_g1 (
    .addr(bus_addr),
    .hit(grp_hit[1])
  );

  rwp_match #(
    .N(`RWP_G2_N),
    .AW(AW),
    .LIST(G2_LIST)
  ) u_g2 (
    .addr(bus_addr),
    .hit(grp_hit[2])
  );

  rwp_match #(
    .N(`RWP_G3_N),
    .AW(AW),
    .LIST(G3_LIST)
  ) u_g3 (
    .addr(bus_addr),
    .hit(grp_hit[3])
  );

  rwp_match #(
    .N(`RWP_G4_N),
    .AW(AW),
    .LIST(G4_LIST)
  ) u_g4 (
    .addr(bus_addr),
    .hit(grp_hit[4])
  );

  rwp_match #(
    .N(`RWP_G5_N),
    .AW(AW),
    .LIST(G5_LIST)
  ) u_g5 (
    .addr(bus_addr),
    .hit(grp_hit[5])
  );

  // group enables from the stored protect state; a protect write
  // therefore opens the guard for the very next bus cycle
  wire [`RWP_NGRP-1:0] grp_en; // bit g: group g writable

  assign grp_en[0] = main_r[`RWP_MAIN_CLK_BIT];
  assign grp_en[1] = main_r[`RWP_MAIN_PM_BIT];
  assign grp_en[2] = main_r[`RWP_MAIN_PORT_BIT];
  assign grp_en[3] = clock4_r[`RWP_CLOCK4_BIT];
  assign grp_en[4] = power_r[`RWP_POWER_BIT];
  // only the exact key opens; any other byte closes, so a key
  // half written by a runaway loop still leaves the group shut
  wire key_open;
  assign key_open = (key_r == `RWP_KEY_OPEN);
  assign grp_en[5] = key_open;

  // write verdict for a non-own address
  wire [`RWP_NGRP-1:0] grp_deny;
  wire deny_any; // the address hits a closed group
  wire wr_ext;
  wire wr_pass;
  wire wr_deny;

  // a group hit without its enable refuses the write
  assign grp_deny = grp_hit & ~grp_en;
  // any refused group blocks; groups never overlap, so at most one
  // bit of grp_deny is set for a given address
  assign deny_any = |grp_deny;
  // addresses outside every list pass untouched: the guard only
  // knows the targets it was given
  assign wr_ext = bus_wr & ~hit_own;
  assign wr_pass = wr_ext & ~deny_any;
  assign wr_deny = wr_ext & deny_any;

  // next value of the protect registers
  always @* begin
    key_nxt = key_r;
    main_nxt = main_r;
    power_nxt = power_r;
    clock4_nxt = clock4_r;
    if (bus_wr) begin
      // protect writes are taken regardless of any enable
      if (hit_key) begin
        key_nxt = bus_wdata;
      end
      // reserved bits masked at the write, so they always read zero
      if (hit_main) begin
        main_nxt = bus_wdata & `RWP_MAIN_MASK;
      end
      if (hit_power) begin
        power_nxt = bus_wdata & `RWP_POWER_MASK;
      end
      if (hit_clock4) begin
        clock4_nxt = bus_wdata & `RWP_CLOCK4_MASK;
      end
    end
  end

  // next value of the status register
  always @* begin
    stat_blk_nxt = stat_blk_r;
    stat_grp_nxt = stat_grp_r;
    // write one to bit 0 clears the sticky flag
    if (bus_wr && hit_stat && bus_wdata[`RWP_STAT_BLK_BIT]) begin
      stat_blk_nxt = 1'b0;
    end
    // a refusal in the same cycle wins over the clear; with one bus
    // the two cannot meet today, but a second master would need it
    if (wr_deny) begin
      stat_blk_nxt = 1'b1;
      stat_grp_nxt = grp_deny;
    end
  end

  // register update
  always @(posedge core_clk) begin
    if (rst) begin
      // everything starts protected
      key_r <= `RWP_RST_KEY;
      main_r <= `RWP_RST_CTRL;
      power_r <= `RWP_RST_CTRL;
      clock4_r <= `RWP_RST_CTRL;
    end else begin
      key_r <= key_nxt;
      main_r <= main_nxt;
      power_r <= power_nxt;
      clock4_r <= clock4_nxt;
    end
  end

  // status update, kept apart so its clear path stays easy to follow
  always @(posedge core_clk) begin
    if (rst) begin
      // no refusal on record after reset
      stat_blk_r <= 1'h0;
      stat_grp_r <= {`RWP_NGRP{1'h0}};
    end else begin
      stat_blk_r <= stat_blk_nxt;
      stat_grp_r <= stat_grp_nxt;
    end
  end

  // gated write towards the system, one cycle behind the cpu
  always @(posedge core_clk) begin
    if (rst) begin
      sys_wr <= 1'b0;
      sys_addr <= {AW{1'b0}};
      sys_wdata <= {DW{1'b0}};
      wr_blocked <= 1'b0;
    end else begin
      // a refused write never reaches the target
      sys_wr <= wr_pass;
      wr_blocked <= wr_deny;
      // address and data only move on a passed write, so a refused
      // value never shows on the system lines, not even for a cycle
      if (wr_pass) begin
        sys_addr <= bus_addr;
        sys_wdata <= bus_wdata;
      end
    end
  end

  // enables shown as they stand after this edge; taken from the next
  // values so the pins agree with what the following write will see
  always @(posedge core_clk) begin
    if (rst) begin
      grp_open <= {`RWP_NGRP{1'b0}};
    end else begin
      grp_open[0] <= main_nxt[`RWP_MAIN_CLK_BIT];
      grp_open[1] <= main_nxt[`RWP_MAIN_PM_BIT];
      grp_open[2] <= main_nxt[`RWP_MAIN_PORT_BIT];
      grp_open[3] <= clock4_nxt[`RWP_CLOCK4_BIT];
      grp_open[4] <= power_nxt[`RWP_POWER_BIT];
      grp_open[5] <= (key_nxt == `RWP_KEY_OPEN);
    end
  end

  // status as read: group of last refusal above the sticky flag,
  // top bit reserved and zero
  wire [DW-1:0] stat_word;
  assign stat_word = {{(DW-`RWP_NGRP-1){1'h0}}, stat_grp_r, stat_blk_r};

  // read mux, value of the register before any same-cycle write;
  // reads have no side effect, so polling the status loses nothing
  reg [DW-1:0] rd_mux;

  always @* begin
    rd_mux = {DW{1'b0}};
    if (hit_key) begin
      rd_mux = key_r;
    end else if (hit_main) begin
      rd_mux = main_r;
    end else if (hit_power) begin
      rd_mux = power_r;
    end else if (hit_clock4) begin
      rd_mux = clock4_r;
    end else if (hit_stat) begin
      rd_mux = stat_word;
    end
  end

  // read data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rst) begin
      bus_rdata <= {DW{1'b0}};
    end else if (bus_rd) begin
      bus_rdata <= rd_mux;
    end else begin
      // zero outside the answer cycle, so stale data never lingers
      bus_rdata <= {DW{1'b0}};
    end
  end

endmodule // rwp_top

/* include/rwp_consts.vh */
// constants for the register write protect block
`ifndef RWP_CONSTS_VH
`define RWP_CONSTS_VH

// bus geometry
`define RWP_AW 20
`define RWP_DW 8

// protect register offsets
`define RWP_OFS_KEY 20'h00007
`define RWP_OFS_MAIN 20'h4004a
`define RWP_OFS_POWER 20'h4004c
`define RWP_OFS_CLOCK4 20'h4405f
// status register offset
`define RWP_OFS_STAT 20'h4004e

// field positions
`define RWP_MAIN_CLK_BIT 0
`define RWP_MAIN_PM_BIT 1
`define RWP_MAIN_PORT_BIT 2
`define RWP_CLOCK4_BIT 7
`define RWP_POWER_BIT 1
`define RWP_STAT_BLK_BIT 0

// writable masks, reserved bits read zero
`define RWP_MAIN_MASK 8'h07
`define RWP_CLOCK4_MASK 8'h80
`define RWP_POWER_MASK 8'h02

// reset values
`define RWP_RST_KEY 8'h00
`define RWP_RST_CTRL 8'h00

// key value that opens the key group
`define RWP_KEY_OPEN 8'haa

// number of guarded groups
`define RWP_NGRP 6

// group 0: clock_mode_a/b/c, processor_mode_d
`define RWP_G0_N 4
`define RWP_G0_LIST {20'h40046, 20'h40047, 20'h4004d, 20'h40048}
// group 1: processor_mode_a/c, chip select opt a/b, inverter a/b, io buf
`define RWP_G1_N 7
`define RWP_G1_LIST {20'h40044, 20'h40053, 20'h40054, 20'h40055, \
  20'h40056, 20'h40057, 20'h40058}
// group 2: port9 direction, port9 pin function 3..7, pll a/b
`define RWP_G2_N 8
`define RWP_G2_LIST {20'h400c0, 20'h400c3, 20'h400c4, 20'h400c5, \
  20'h400c6, 20'h400c7, 20'h40020, 20'h40021}
// group 3: clock_mode_d
`define RWP_G3_N 1
`define RWP_G3_LIST {20'h4005a}
// group 4: regulator, low voltage detect, voltage detect
`define RWP_G4_N 3
`define RWP_G4_LIST {20'h40060, 20'h40062, 20'h40064}
// group 5: clock divider, flash mode, peripheral bus, ext bus, boundaries
`define RWP_G5_N 13
`define RWP_G5_LIST {20'h00004, 20'h00008, 20'h0001e, 20'h0001f, \
  20'h00010, 20'h00013, 20'h00014, 20'h00015, 20'h00016, 20'h00017, \
  20'h00018, 20'h00019, 20'h0001a}

`endif

/* src/rwp_match.v */
// address list matcher for one guarded group
`timescale 1ns/10ps
module rwp_match #(
  parameter N = 1,
  parameter AW = 20,
  parameter [N*AW-1:0] LIST = {N*AW{1'b0}}
) (
  input wire [AW-1:0] addr,
  output wire hit
);
  // one compare per listed address
  wire [N-1:0] eq;
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_cmp
      assign eq[i] = (addr == LIST[i*AW +: AW]);
    end
  endgenerate
  // any match marks the address as part of the group
  assign hit = |eq;
endmodule // rwp_match

/* test/rwp_top_properties.sv */
// checker: write protect timing and gating properties
`timescale 1ns/10ps
module rwp_top_props (
  input wire core_clk,
  input wire rst,
  input wire [19:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_rdata,
  input wire sys_wr,
  input wire [19:0] sys_addr,
  input wire [7:0] sys_wdata,
  input wire wr_blocked,
  input wire [5:0] grp_open
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // one guarded place per group: lands only while its enable is up
  chk_clk_gate: assert property (bus_wr && bus_addr == 20'h40046
    |=> sys_wr == $past(grp_open[0]) && wr_blocked != sys_wr)
    else $error("clock group gate wrong");
  chk_pm_gate: assert property (bus_wr && bus_addr == 20'h40044
    |=> sys_wr == $past(grp_open[1]) && wr_blocked != sys_wr)
    else $error("mode group gate wrong");
  chk_port_gate: assert property (bus_wr && bus_addr == 20'h40020
    |=> sys_wr == $past(grp_open[2]) && wr_blocked != sys_wr)
    else $error("port group gate wrong");
  chk_clk4_gate: assert property (bus_wr && bus_addr == 20'h4005a
    |=> sys_wr == $past(grp_open[3]) && wr_blocked != sys_wr)
    else $error("clock4 gate wrong");
  chk_pwr_gate: assert property (bus_wr && bus_addr == 20'h40060
    |=> sys_wr == $past(grp_open[4]) && wr_blocked != sys_wr)
    else $error("power gate wrong");
  chk_key_gate: assert property (bus_wr && bus_addr == 20'h00004
    |=> sys_wr == $past(grp_open[5]) && wr_blocked != sys_wr)
    else $error("key gate wrong");
  // enables follow the protect writes at once
  chk_main_load: assert property (bus_wr && bus_addr == 20'h4004a
    |=> grp_open[2:0] == $past(bus_wdata[2:0]))
    else $error("main enables wrong");
  chk_key_load: assert property (bus_wr && bus_addr == 20'h00007
    |=> grp_open[5] == ($past(bus_wdata) == 8'haa))
    else $error("key enable wrong");
  // protect writes stay local and are never refused
  chk_prot_quiet: assert property (bus_wr && (bus_addr == 20'h4004a
    || bus_addr == 20'h4004c || bus_addr == 20'h4405f
    || bus_addr == 20'h00007) |=> !sys_wr && !wr_blocked)
    else $error("protect write leaked");
  chk_pass_data: assert property (sys_wr |-> $past(bus_wr)
    && sys_addr == $past(bus_addr) && sys_wdata == $past(bus_wdata))
    else $error("passed write mangled");
endmodule // rwp_top_props

bind rwp_top rwp_top_props u_props (
  .core_clk(core_clk),
  .rst(rst),
  .bus_addr(bus_addr),
  .bus_wdata(bus_wdata),
  .bus_wr(bus_wr),
  .bus_rd(bus_rd),
  .bus_rdata(bus_rdata),
  .sys_wr(sys_wr),
  .sys_addr(sys_addr),
  .sys_wdata(sys_wdata),
  .wr_blocked(wr_blocked),
  .grp_open(grp_open)
);

/* test/tb_rwp_top.sv */
// testbench for the register write protect block
`timescale 1ns/10ps
module tb_rwp_top;
  reg core_clk = 1'h0; // 40 MHz
  reg rst = 1'h1;
  reg [19:0] bus_addr = 20'h0;
  reg [7:0] bus_wdata = 8'h0;
  reg bus_wr = 1'h0;
  reg bus_rd = 1'h0;
  wire [7:0] bus_rdata;
  wire sys_wr;
  wire [19:0] sys_addr;
  wire [7:0] sys_wdata;
  wire wr_blocked;
  wire [5:0] grp_open;
  integer err_total = 0;
  integer n_tests = 0;
  integer i;
  integer j;
  reg [19:0] mbr [0:8]; // further documented group members
  reg [47:0] tbl [0:5]; // protect reg, open value, guarded place
  reg [47:0] e;

  rwp_top u_dut (
    .core_clk(core_clk),
    .rst(rst),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .sys_wr(sys_wr),
    .sys_addr(sys_addr),
    .sys_wdata(sys_wdata),
    .wr_blocked(wr_blocked),
    .grp_open(grp_open)
  );

  // free running clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  // count one compare, shout on mismatch
  task chk(input [27:0] g, input [27:0] x);
    begin
      n_tests = n_tests + 1;
      if (g !== x) begin
        err_total = err_total + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
    end
  endtask

  // one write; x = {refused, passed}, 0 for a protect reg
  task wr(input [19:0] a, input [7:0] d, input [1:0] x);
    begin
      @(posedge core_clk);
      bus_wr <= 1'h1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge core_clk);
      bus_wr <= 1'h0;
      #1;
      chk({wr_blocked, sys_wr}, x);
      if (x == 2'h1) chk({sys_wdata, sys_addr}, {d, a});
    end
  endtask

  // one read, data looked at in the following cycle only
  task rd(input [19:0] a, input [7:0] x);
    begin
      @(posedge core_clk);
      bus_rd <= 1'h1;
      bus_addr <= a;
      @(posedge core_clk);
      bus_rd <= 1'h0;
      #1;
      chk(bus_rdata, x);
    end
  endtask

  // reset state, writable masks, unguarded places
  task t_regs;
    begin
      rd(20'h4004a, 8'h00);
      chk(grp_open, 6'h00);
      wr(20'h4004a, 8'hff, 2'h0);
      rd(20'h4004a, 8'h07);
      wr(20'h4405f, 8'hff, 2'h0);
      rd(20'h4405f, 8'h80);
      wr(20'h4004c, 8'hff, 2'h0);
      rd(20'h4004c, 8'h02);
      wr(20'h00007, 8'hff, 2'h0);
      rd(20'h00007, 8'hff);
      chk(grp_open, 6'h1f);
      rd(20'h12345, 8'h00);
      wr(20'h12345, 8'h5a, 2'h1);
    end
  endtask

  // each group refused while closed, taken right after opening
  task t_gates;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        e = tbl[i + 2];
        wr(e[47:28], 8'h00, 2'h0);
      end
      for (i = 0; i < 6; i = i + 1) begin
        e = tbl[i];
        wr(e[19:0], 8'h3c, 2'h2);
        wr(e[47:28], e[27:20], 2'h0);
        wr(e[19:0], 8'hc3, 2'h1);
        chk(grp_open, 6'h01 << i);
        wr(e[47:28], 8'h00, 2'h0);
      end
      rd(20'h4004e, 8'h41);
    end
  endtask

  // only the exact key opens the key group
  task t_key;
    begin
      wr(20'h00007, 8'hab, 2'h0);
      wr(20'h0001a, 8'h11, 2'h2);
      wr(20'h00007, 8'h2a, 2'h0);
      wr(20'h00008, 8'h22, 2'h2);
      wr(20'h00007, 8'haa, 2'h0);
      wr(20'h0001a, 8'h33, 2'h1);
      rd(20'h00007, 8'haa);
    end
  endtask

  // nine further members from mbr: refused while shut, passed once opened
  task t_members;
    begin
      for (j = 0; j < 2; j = j + 1) begin
        for (i = 0; i < 9; i = i + 1) begin
          wr(mbr[i], 8'h96, j ? 2'h1 : 2'h2);
        end
        wr(20'h4004a, j ? 8'h00 : 8'h07, 2'h0);
        wr(20'h4004c, j ? 8'h00 : 8'h02, 2'h0);
        wr(20'h00007, j ? 8'h00 : 8'haa, 2'h0);
      end
    end
  endtask

  // back to back strobes, one-cycle pulses, status clear
  task t_b2b;
    begin
      @(posedge core_clk);
      bus_wr <= 1'h1;
      bus_addr <= 20'h4004a;
      bus_wdata <= 8'h01;
      @(posedge core_clk);
      bus_addr <= 20'h40046;
      bus_wdata <= 8'h5a;
      #1;
      chk(grp_open, 6'h21);
      @(posedge core_clk);
      bus_addr <= 20'h40060;
      bus_wdata <= 8'h77;
      #1;
      chk({wr_blocked, sys_wr, sys_addr}, {2'h1, 20'h40046});
      @(posedge core_clk);
      bus_wr <= 1'h0;
      bus_rd <= 1'h1;
      bus_addr <= 20'h4004a;
      #1;
      chk({wr_blocked, sys_wr, sys_addr}, {2'h2, 20'h40046});
      @(posedge core_clk);
      bus_rd <= 1'h0;
      #1;
      chk({wr_blocked, sys_wr, bus_rdata}, 10'h001);
      @(posedge core_clk);
      #1;
      chk(bus_rdata, 8'h00);
      rd(20'h4004e, 8'h21);
      wr(20'h4004e, 8'h00, 2'h0);
      rd(20'h4004e, 8'h21);
      wr(20'h4004e, 8'h01, 2'h0);
      rd(20'h4004e, 8'h20);
      wr(20'h4004a, 8'h00, 2'h0);
    end
  endtask

  // reset in mid-run closes every group and clears the record
  task t_reset;
    begin
      @(posedge core_clk);
      rst <= 1'h1;
      repeat (2) @(posedge core_clk);
      rst <= 1'h0;
      #1;
      chk({sys_wdata, sys_addr}, 28'h0);
      chk({bus_rdata, wr_blocked, sys_wr, grp_open}, 16'h0);
      rd(20'h00007, 8'h00);
      rd(20'h4004e, 8'h00);
      wr(20'h00004, 8'h00, 2'h2);
    end
  endtask

  // closing verdict
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask

  // main sequence
  initial begin
    tbl[0] = {20'h4004a, 8'h01, 20'h40046};
    tbl[1] = {20'h4004a, 8'h02, 20'h40044};
    tbl[2] = {20'h4004a, 8'h04, 20'h40020};
    tbl[3] = {20'h4405f, 8'h80, 20'h4005a};
    tbl[4] = {20'h4004c, 8'h02, 20'h40060};
    tbl[5] = {20'h00007, 8'haa, 20'h00004};
    mbr[0] = 20'h40047;
    mbr[1] = 20'h4004d;
    mbr[2] = 20'h40048;
    mbr[3] = 20'h40053;
    mbr[4] = 20'h40021;
    mbr[5] = 20'h40062;
    mbr[6] = 20'h40064;
    mbr[7] = 20'h0001e;
    mbr[8] = 20'h0001f;
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    t_regs;
    t_gates;
    t_members;
    t_key;
    t_b2b;
    t_reset;
    report_and_stop;
  end
endmodule // tb_rwp_top
